// ### srwd_cpu_model.sv
// Processor side model: strobe driver with tri-state and weak pull
`timescale 1ns/1ps
`default_nettype none
module srwd_cpu_model
  import srwd_pkg::*;
(
  input wire logic mclk,
  input wire logic drive_en,
  input wire logic service,
  input wire srwd_pull_s pull,
  output logic pin
);
  logic drv_q;
  int cnt_q = 0;
  // low, one high cycle in forty; changes after the sampling edge
  always @(posedge mclk) begin
    cnt_q <= service ? (cnt_q + 1) % 40 : 0;
    drv_q <= service && cnt_q == 38;
  end
  assign pin = drive_en ? drv_q : pull.pull_o;
endmodule : srwd_cpu_model
`default_nettype wire

// ### srwd_filter.sv
// Input debounce filter: output follows input after stable run
`timescale 1ns/1ps
`default_nettype none
module srwd_filter #(
  parameter int CYC = 50,
  parameter logic INIT = 1'b0
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic din,
  output logic dout
);
  localparam int W = $clog2(CYC + 1);
  logic [W-1:0] cnt_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
      dout <= INIT;
    end else if (din == dout) begin
      cnt_q <= '0;
    end else if (cnt_q >= W'(CYC - 1)) begin
      cnt_q <= '0;
      dout <= din;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule : srwd_filter
`default_nettype wire

// ### srwd_pkg.sv
// Types for the supply reset watchdog supervisor
package srwd_pkg;
  typedef enum logic [1:0] {
    SRWD_HOLD,
    SRWD_RUN
  } srwd_state_e;
  typedef struct packed {
    logic reset_n;
    logic reset;
  } srwd_rst_s;
  typedef struct packed {
    logic pull_o;
    logic pull_oe;
  } srwd_pull_s;
endpackage : srwd_pkg

// ### srwd_regs.svh
// Timing constants for the supply reset watchdog supervisor
`ifndef SRWD_REGS_SVH
`define SRWD_REGS_SVH
`define SRWD_CLK_HZ 50000000
`define SRWD_HOLD_MS 140
`define SRWD_HOLD_CYC ((`SRWD_CLK_HZ / 1000) * `SRWD_HOLD_MS)
`define SRWD_WD_MS 1120
`define SRWD_WD_CYC ((`SRWD_CLK_HZ / 1000) * `SRWD_WD_MS)
`define SRWD_DIP_NS 2000
`define SRWD_DIP_CYC ((`SRWD_CLK_HZ / 1000000) * `SRWD_DIP_NS / 1000)
`define SRWD_MR_NS 1000
`define SRWD_MR_CYC ((`SRWD_CLK_HZ / 1000000) * `SRWD_MR_NS / 1000)
`define SRWD_RST_HOLD 1'b1
`endif

// ### srwd_top.sv
// Supervisor core: supply, manual reset and watchdog reset generation
// Contract
// R1: Reset stays asserted at least 140 ms after supply recovers.
// R2: Supply below threshold asserts every reset output.
// R3: Low manual reset input asserts the reset outputs.
// R4: Manual reset is debounced and yields at least 140 ms pulse.
// R5: Manual reset hold period starts when the input returns high.
// R6: No strobe edge within 1.12 s asserts reset.
// R7: Watchdog counts only while reset is inactive.
// R8: Any strobe edge clears the watchdog count.
// R9: Expiry gives a hold period then restarts the watchdog.
// R10: Floating strobe input disables watchdog resets.
// R11: Strobe weakly pulled low 7/8, high 1/8 of each period.
// R12: Probing repeats each period until strobe is driven; the code keeps probing every period while driven too.
// R13: Processor should keep strobe low, pulsing high to service.
// R14: Supply dips under about 2 us do not cause reset.
// R15: Hold period lies between 140 and 400 ms.
// R16: Watchdog timeout lies between 1.12 and 3.20 s.
// R17: Manual reset ignores 100 ns glitches, acts within 5 us.
// R18: Active-high reset is always the inverse of active-low.
// R19: Counters time intervals; each reset cause reloads hold.
`timescale 1ns/1ps
`default_nettype none
`include "srwd_regs.svh"
module srwd_top
  import srwd_pkg::*;
#(
  // R15 R16 minimum hold and timeout
  parameter int HOLD_CYC = `SRWD_HOLD_CYC,
  parameter int WD_CYC = `SRWD_WD_CYC,
  parameter int DIP_CYC = `SRWD_DIP_CYC,
  parameter int MR_CYC = `SRWD_MR_CYC
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic supply_ok,
  input wire logic manual_reset_n,
  input wire logic watchdog_strobe_in,
  output srwd_rst_s rst_out,
  output srwd_pull_s strobe_pull
);
  localparam int HW = $clog2(HOLD_CYC + 1);
  localparam int WW = $clog2(WD_CYC + 1);
  localparam int PROBE_AT = WD_CYC - WD_CYC / 8;

  logic supply_f;
  logic mr_f;
  logic strobe_q;
  logic strobe_edge;
  logic driven_q;
  logic seen_hi_q;
  logic quiet_q;
  logic cause;
  logic wd_expire;
  logic [HW-1:0] hold_q;
  logic [WW-1:0] wd_q;
  logic [WW-1:0] pr_q;
  srwd_state_e state_q;

  // Probe phase decode
  function automatic logic at_phase(input logic [WW-1:0] cnt, input int pos);
    return cnt == WW'(pos);
  endfunction : at_phase

  // R14 dip filter
  srwd_filter #(.CYC(DIP_CYC), .INIT(1'b0)) u_supply (
    .mclk(mclk),
    .nrst(nrst),
    .din(supply_ok),
    .dout(supply_f)
  );

  // R4 R17 manual debounce
  srwd_filter #(.CYC(MR_CYC), .INIT(1'b1)) u_mr (
    .mclk(mclk),
    .nrst(nrst),
    .din(manual_reset_n),
    .dout(mr_f)
  );

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= watchdog_strobe_in;
    end
  end

  // R8 edge detect
  assign strobe_edge = strobe_q != watchdog_strobe_in;

  // R2 R3 R5 causes
  assign cause = !supply_f || !mr_f || wd_expire;
  assign wd_expire = (state_q == SRWD_RUN) && driven_q
                     && (wd_q >= WW'(WD_CYC - 1));

  // R1 R19 hold reload
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hold_q <= '0;
      state_q <= SRWD_HOLD;
    end else begin
      case (state_q)
        SRWD_HOLD: begin
          if (cause) begin
            hold_q <= '0;
          end else if (hold_q >= HW'(HOLD_CYC - 1)) begin
            state_q <= SRWD_RUN;
          end else begin
            hold_q <= hold_q + 1'b1;
          end
        end
        SRWD_RUN: begin
          if (cause) begin
            // R9 expiry re-enters hold
            hold_q <= '0;
            state_q <= SRWD_HOLD;
          end
        end
        default: begin
          state_q <= SRWD_HOLD;
        end
      endcase
    end
  end

  // R7 R8 watchdog count
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wd_q <= '0;
    end else if (state_q != SRWD_RUN || strobe_edge || cause) begin
      wd_q <= '0;
    end else if (wd_q >= WW'(WD_CYC - 1)) begin
      wd_q <= '0;
    end else begin
      wd_q <= wd_q + 1'b1;
    end
  end

  // R11 R12 probe phase; kept apart from the strobe-cleared count
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pr_q <= '0;
    end else if (state_q != SRWD_RUN || pr_q >= WW'(WD_CYC - 1)) begin
      pr_q <= '0;
    end else begin
      pr_q <= pr_q + 1'b1;
    end
  end

  // Pin level just after the pull went high
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      seen_hi_q <= 1'b0;
    end else if (state_q == SRWD_RUN && at_phase(pr_q, PROBE_AT + 1)) begin
      seen_hi_q <= watchdog_strobe_in;
    end
  end

  // Edges away from the pull steps mean a real driver
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      quiet_q <= 1'b1;
    end else if (state_q != SRWD_RUN) begin
      quiet_q <= 1'b1;
    end else if (strobe_edge && !at_phase(pr_q, PROBE_AT + 1)
                 && !at_phase(pr_q, 1)) begin
      quiet_q <= 1'b0;
    end else if (at_phase(pr_q, 2)) begin
      quiet_q <= 1'b1;
    end
  end

  // R10 floating when pin followed both pull steps and nothing else
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      driven_q <= 1'b1;
    end else if (state_q == SRWD_RUN && at_phase(pr_q, 1)) begin
      driven_q <= !(seen_hi_q && quiet_q && !watchdog_strobe_in);
    end
  end

  // R11 weak pull pattern; a floating pin's own steps service the count
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      strobe_pull <= '{pull_o: 1'b0, pull_oe: 1'b1};
    end else begin
      strobe_pull.pull_oe <= 1'b1;
      strobe_pull.pull_o <= (pr_q >= WW'(PROBE_AT));
    end
  end

  // R18 complementary outputs
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_out <= '{reset_n: 1'b0, reset: `SRWD_RST_HOLD};
    end else begin
      rst_out.reset_n <= (state_q == SRWD_RUN) && !cause;
      rst_out.reset <= !((state_q == SRWD_RUN) && !cause);
    end
  end

  property p_inv;
    @(posedge mclk) disable iff (!nrst) rst_out.reset == !rst_out.reset_n;
  endproperty
  a_inv: assert property (p_inv) else $error("reset pair mismatch"); // R18

  property p_supply;
    @(posedge mclk) disable iff (!nrst) !supply_f |=> !rst_out.reset_n;
  endproperty
  a_supply: assert property (p_supply) else $error("supply low no reset"); // R2

  property p_mr;
    @(posedge mclk) disable iff (!nrst) !mr_f |=> !rst_out.reset_n;
  endproperty
  a_mr: assert property (p_mr) else $error("manual low no reset"); // R3

  property p_hold;
    @(posedge mclk) disable iff (!nrst)
      $rose(state_q == SRWD_HOLD) |-> hold_q == '0;
  endproperty
  a_hold: assert property (p_hold) else $error("hold not reloaded"); // R19

  property p_release;
    @(posedge mclk) disable iff (!nrst)
      $rose(state_q == SRWD_RUN) |-> $past(hold_q) == HW'(HOLD_CYC - 1);
  endproperty
  a_release: assert property (p_release) else $error("early release"); // R1

  property p_wdidle;
    @(posedge mclk) disable iff (!nrst) state_q == SRWD_HOLD |=> wd_q == '0;
  endproperty
  a_wdidle: assert property (p_wdidle) else $error("wd ran in reset"); // R7

  property p_edge;
    @(posedge mclk) disable iff (!nrst) strobe_edge |=> wd_q == '0;
  endproperty
  a_edge: assert property (p_edge) else $error("edge kept count"); // R8

  property p_expire;
    @(posedge mclk) disable iff (!nrst)
      wd_expire |=> state_q == SRWD_HOLD ##1 !rst_out.reset_n;
  endproperty
  a_expire: assert property (p_expire) else $error("expiry no reset"); // R6

  property p_float;
    @(posedge mclk) disable iff (!nrst)
      (state_q == SRWD_RUN && !driven_q && supply_f && mr_f)
      |=> state_q == SRWD_RUN;
  endproperty
  a_float: assert property (p_float) else $error("float caused reset"); // R10

  property p_pull;
    @(posedge mclk) disable iff (!nrst)
      pr_q == WW'(PROBE_AT) |=> strobe_pull.pull_o;
  endproperty
  a_pull: assert property (p_pull) else $error("pull not high"); // R11
endmodule : srwd_top
`default_nettype wire

// ### test_supply_reset_watchdog_supervisor.sv
// Testbench for the supply reset watchdog supervisor
`timescale 1ns/1ps
`default_nettype none
module test_supply_reset_watchdog_supervisor
  import srwd_pkg::*;
;
  logic mclk, nrst, supply_ok, manual_reset_n, drive_en, service, pin;
  srwd_rst_s rst_out;
  srwd_pull_s strobe_pull;
  int fails, checks, n, hi;
  srwd_top #(.HOLD_CYC(50), .WD_CYC(160), .DIP_CYC(4), .MR_CYC(4))
    srwd_top_inst (.mclk(mclk), .nrst(nrst), .supply_ok(supply_ok),
    .manual_reset_n(manual_reset_n), .watchdog_strobe_in(pin),
    .rst_out(rst_out), .strobe_pull(strobe_pull));
  srwd_cpu_model srwd_cpu_model_inst (.mclk(mclk), .drive_en(drive_en),
    .service(service), .pull(strobe_pull), .pin(pin));
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  // Bounded wait, cycle count left in n
  task automatic wait_rst(input logic lvl, input int lim);
    n = 0;
    while (rst_out.reset_n !== lvl && n < lim) begin
      @(negedge mclk);
      n++;
    end
  endtask : wait_rst
  task automatic t_power;
    wait_rst(1'b1, 200);
    chk("power hold", 32'(n >= 54 && n < 70), 1);
    chk("inverse", 32'(rst_out.reset), 0);
  endtask : t_power
  task automatic t_supply;
    supply_ok = 1'b0;
    @(negedge mclk);
    supply_ok = 1'b1;
    repeat (10) @(negedge mclk);
    chk("dip", 32'(rst_out.reset_n), 1);
    supply_ok = 1'b0;
    repeat (10) @(negedge mclk);
    chk("brownout", 32'(rst_out.reset_n), 0);
    chk("inverse", 32'(rst_out.reset), 1);
    supply_ok = 1'b1;
    wait_rst(1'b1, 200);
    chk("supply hold", 32'(n >= 54 && n < 70), 1);
  endtask : t_supply
  task automatic t_manual;
    manual_reset_n = 1'b0;
    @(negedge mclk);
    manual_reset_n = 1'b1;
    repeat (10) @(negedge mclk);
    chk("glitch", 32'(rst_out.reset_n), 1);
    manual_reset_n = 1'b0;
    repeat (10) @(negedge mclk);
    chk("manual", 32'(rst_out.reset_n), 0);
    repeat (100) @(negedge mclk);
    manual_reset_n = 1'b1;
    wait_rst(1'b1, 200);
    chk("release hold", 32'(n >= 54 && n < 70), 1);
  endtask : t_manual
  task automatic t_wdog;
    drive_en = 1'b1;
    service = 1'b1;
    repeat (600) @(negedge mclk);
    chk("serviced", 32'(rst_out.reset_n), 1);
    service = 1'b0;
    wait_rst(1'b0, 300);
    chk("expiry", 32'(n >= 120 && n < 175), 1);
    wait_rst(1'b1, 200);
    chk("expiry hold", 32'(n >= 50 && n < 60), 1);
    wait_rst(1'b0, 300);
    chk("restart", 32'(n >= 158 && n < 175), 1);
  endtask : t_wdog
  task automatic t_float;
    drive_en = 1'b0;
    wait_rst(1'b1, 200);
    hi = 0;
    n = 0;
    repeat (480) begin
      @(negedge mclk);
      hi += int'(strobe_pull.pull_o === 1'b1);
      n += int'(rst_out.reset_n !== 1'b1);
    end
    chk("float reset", 32'(n), 0);
    chk("pull high share", 32'(hi >= 40 && hi <= 80), 1);
    chk("pull enable", 32'(strobe_pull.pull_oe), 1);
  endtask : t_float
  task automatic print_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    #400000;
    fails++;
    print_verdict();
  end
  initial begin
    fails = 0;
    checks = 0;
    nrst = 1'b0;
    supply_ok = 1'b1;
    manual_reset_n = 1'b1;
    drive_en = 1'b1;
    service = 1'b0;
    repeat (8) @(negedge mclk);
    nrst = 1'b1;
    t_power();
    t_supply();
    t_manual();
    t_wdog();
    t_float();
    print_verdict();
  end
endmodule : test_supply_reset_watchdog_supervisor
`default_nettype wire
